//--- logic/pie_pkg.sv
// Constants for the peripheral interrupt enable and priority register bank
package pie_pkg;

	// ========================================
	// Register byte offsets
	localparam logic [7:0] PIE_OFS_EN_A = 8'h00;
	localparam logic [7:0] PIE_OFS_EN_B = 8'h04;
	localparam logic [7:0] PIE_OFS_PR_A = 8'h08;
	localparam logic [7:0] PIE_OFS_PR_B = 8'h0c;
	localparam logic [7:0] PIE_OFS_CTRL = 8'h10;
	localparam logic [7:0] PIE_OFS_FLAG_A = 8'h14;
	localparam logic [7:0] PIE_OFS_FLAG_B = 8'h18;

	// ========================================
	// Implemented bits and read-as-one bits
	localparam logic [7:0] PIE_IMPL_A = 8'hfb;
	localparam logic [7:0] PIE_IMPL_B = 8'h1e;
	localparam logic [7:0] PIE_PR_A_ONES = 8'h04;
	localparam logic [7:0] PIE_PR_B_ONES = 8'h01;

	// ========================================
	// Values after reset
	localparam logic [7:0] PIE_EN_RST = 8'h00;
	localparam logic [7:0] PIE_PR_A_RST = 8'hfb;
	localparam logic [7:0] PIE_PR_B_RST = 8'h1e;
	localparam logic [7:0] PIE_FLAG_RST = 8'h00;
	localparam logic [2:0] PIE_CTRL_RST = 3'h0;

	// ========================================
	// Control register fields
	localparam int PIE_CTRL_PRIO_ON = 0;
	localparam int PIE_CTRL_GLOBAL_HIGH = 1;
	localparam int PIE_CTRL_PERIPH_EN = 2;

	// ========================================
	// Source bit positions
	localparam int PIE_BIT_PARALLEL = 7;
	localparam int PIE_BIT_CONVERTER = 6;
	localparam int PIE_BIT_UART_RX = 5;
	localparam int PIE_BIT_UART_TX = 4;
	localparam int PIE_BIT_SYNC_SERIAL = 3;
	localparam int PIE_BIT_TIMER2_MATCH = 1;
	localparam int PIE_BIT_TIMER1_OVF = 0;
	localparam int PIE_BIT_NV_WRITE = 4;
	localparam int PIE_BIT_BUS_COLLISION = 3;
	localparam int PIE_BIT_LOW_VOLTAGE = 2;
	localparam int PIE_BIT_TIMER3_OVF = 1;

	// ========================================
	// Bus responses
	localparam logic [1:0] PIE_RESP_OKAY = 2'h0;
	localparam logic [1:0] PIE_RESP_DECERR = 2'h3;

endpackage

//--- logic/pie_top.sv
// Peripheral interrupt enable/priority bank with AXI4-Lite register access
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

module pie_top
	import pie_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	// Source events, one-cycle pulses on this clock
	input wire logic [7:0] i_event_a,
	input wire logic [7:0] i_event_b,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Requests toward the core
	output logic o_irq_high,
	output logic o_irq_low,
	output logic o_irq,
	output logic o_priority_levels_on
);

	// ========================================
	// Register state
	logic [7:0] en_a_q;
	logic [7:0] en_b_q;
	logic [7:0] pr_a_q;
	logic [7:0] pr_b_q;
	logic [7:0] flag_a_q;
	logic [7:0] flag_b_q;
	logic [7:0] flag_a_d;
	logic [7:0] flag_b_d;
	logic priority_levels_on_q;
	logic global_high_q;
	logic peripheral_global_en_q;

	// ========================================
	// Bus state
	logic aw_have_q;
	logic w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic ar_take;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic wr_hit;
	logic [7:0] rd_byte;
	logic rd_hit;

	// ========================================
	// Write address and data channels
	assign o_awready = ~aw_have_q & ~bvalid_q;
	assign o_wready = ~w_have_q & ~bvalid_q;
	assign aw_take = i_ce & i_awvalid & o_awready;
	assign w_take = i_ce & i_wvalid & o_wready;

	// A write completes once both halves are present, in either order
	assign wr_fire = (aw_have_q | aw_take) & (w_have_q | w_take) & ~bvalid_q & i_ce;
	assign wr_addr = aw_have_q ? awaddr_q : i_awaddr;
	assign wr_byte = w_have_q ? wbyte_q : i_wdata[7:0];
	assign wr_lane = w_have_q ? wlane_q : i_wstrb[0];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			aw_have_q <= 1'b0;
			awaddr_q <= '0;
		end else if (i_ce) begin
			if (wr_fire) begin
				aw_have_q <= 1'b0;
			end else if (aw_take) begin
				aw_have_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			w_have_q <= 1'b0;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
		end else if (i_ce) begin
			if (wr_fire) begin
				w_have_q <= 1'b0;
			end else if (w_take) begin
				w_have_q <= 1'b1;
				wbyte_q <= i_wdata[7:0];
				wlane_q <= i_wstrb[0];
			end
		end
	end

	always_comb begin
		case (wr_addr)
			PIE_OFS_EN_A, PIE_OFS_EN_B, PIE_OFS_PR_A, PIE_OFS_PR_B,
			PIE_OFS_CTRL, PIE_OFS_FLAG_A, PIE_OFS_FLAG_B: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ========================================
	// Write response
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= PIE_RESP_OKAY;
		end else if (i_ce) begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? PIE_RESP_OKAY : PIE_RESP_DECERR;
			end else if (i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ========================================
	// Configuration registers
	// Only byte lane 0 carries data; upper lanes are ignored
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			en_a_q <= PIE_EN_RST;
			en_b_q <= PIE_EN_RST;
		end else if (i_ce && wr_fire && wr_lane) begin
			if (wr_addr == PIE_OFS_EN_A) begin
				en_a_q <= wr_byte & PIE_IMPL_A;
			end
			if (wr_addr == PIE_OFS_EN_B) begin
				en_b_q <= wr_byte & PIE_IMPL_B;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pr_a_q <= PIE_PR_A_RST;
			pr_b_q <= PIE_PR_B_RST;
		end else if (i_ce && wr_fire && wr_lane) begin
			if (wr_addr == PIE_OFS_PR_A) begin
				pr_a_q <= wr_byte & PIE_IMPL_A;
			end
			if (wr_addr == PIE_OFS_PR_B) begin
				pr_b_q <= wr_byte & PIE_IMPL_B;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			priority_levels_on_q <= PIE_CTRL_RST[PIE_CTRL_PRIO_ON];
			global_high_q <= PIE_CTRL_RST[PIE_CTRL_GLOBAL_HIGH];
			peripheral_global_en_q <= PIE_CTRL_RST[PIE_CTRL_PERIPH_EN];
		end else if (i_ce && wr_fire && wr_lane && wr_addr == PIE_OFS_CTRL) begin
			priority_levels_on_q <= wr_byte[PIE_CTRL_PRIO_ON];
			global_high_q <= wr_byte[PIE_CTRL_GLOBAL_HIGH];
			peripheral_global_en_q <= wr_byte[PIE_CTRL_PERIPH_EN];
		end
	end

	// ========================================
	// Sticky flags, write one to clear
	// A new event in the clearing cycle survives: set wins over clear
	logic [7:0] clr_a;
	logic [7:0] clr_b;

	always_comb begin
		clr_a = 8'h00;
		clr_b = 8'h00;
		if (wr_fire && wr_lane && wr_addr == PIE_OFS_FLAG_A) begin
			clr_a = wr_byte;
		end
		if (wr_fire && wr_lane && wr_addr == PIE_OFS_FLAG_B) begin
			clr_b = wr_byte;
		end
	end

	generate
		for (genvar b = 0; b < 8; b++) begin : g_flag
			// Flags latch whatever the enable or global bits say
			assign flag_a_d[b] = PIE_IMPL_A[b] & (i_event_a[b] | (flag_a_q[b] & ~clr_a[b]));
			assign flag_b_d[b] = PIE_IMPL_B[b] & (i_event_b[b] | (flag_b_q[b] & ~clr_b[b]));
		end
	endgenerate

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			flag_a_q <= PIE_FLAG_RST;
			flag_b_q <= PIE_FLAG_RST;
		end else if (i_ce) begin
			flag_a_q <= flag_a_d;
			flag_b_q <= flag_b_d;
		end
	end

	// ========================================
	// Request generation
	logic [7:0] pend_a;
	logic [7:0] pend_b;
	logic any_pend;
	logic any_high;
	logic any_low;
	logic irq_high_d;
	logic irq_low_d;

	assign pend_a = flag_a_q & en_a_q;
	assign pend_b = flag_b_q & en_b_q;
	assign any_pend = |{pend_a, pend_b};
	assign any_high = |{pend_a & pr_a_q, pend_b & pr_b_q};
	assign any_low = |{pend_a & ~pr_a_q, pend_b & ~pr_b_q};

	always_comb begin
		if (priority_levels_on_q) begin
			irq_high_d = any_high & global_high_q;
			irq_low_d = any_low & peripheral_global_en_q;
		end else begin
			// Single level: priority bits ignored, both globals needed
			irq_high_d = any_pend & global_high_q & peripheral_global_en_q;
			irq_low_d = 1'b0;
		end
	end

	// Registered so the core sees glitch-free levels; costs one cycle
	logic irq_high_q;
	logic irq_low_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			irq_high_q <= 1'b0;
			irq_low_q <= 1'b0;
		end else if (i_ce) begin
			irq_high_q <= irq_high_d;
			irq_low_q <= irq_low_d;
		end
	end

	assign o_irq_high = irq_high_q;
	assign o_irq_low = irq_low_q;
	assign o_irq = irq_high_q | irq_low_q;
	assign o_priority_levels_on = priority_levels_on_q;

	// ========================================
	// Read channel
	always_comb begin
		rd_hit = 1'b1;
		case (i_araddr)
			PIE_OFS_EN_A: rd_byte = en_a_q;
			PIE_OFS_EN_B: rd_byte = en_b_q & PIE_IMPL_B;
			PIE_OFS_PR_A: rd_byte = pr_a_q | PIE_PR_A_ONES;
			PIE_OFS_PR_B: rd_byte = pr_b_q | PIE_PR_B_ONES;
			PIE_OFS_CTRL: rd_byte = {5'h00, peripheral_global_en_q, global_high_q, priority_levels_on_q};
			PIE_OFS_FLAG_A: rd_byte = flag_a_q;
			PIE_OFS_FLAG_B: rd_byte = flag_b_q;
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign o_arready = ~rvalid_q;
	assign ar_take = i_ce & i_arvalid & ~rvalid_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= PIE_RESP_OKAY;
		end else if (i_ce) begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_hit ? PIE_RESP_OKAY : PIE_RESP_DECERR;
			end else if (i_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule

//--- verif/pie_chk_sva.sv
// Checker for the peripheral interrupt enable/priority bank ports
`timescale 1ns/1ns

module pie_chk
	import pie_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic i_rready,
	input wire logic i_bready,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic o_irq,
	input wire logic o_irq_high,
	input wire logic o_irq_low,
	input wire logic o_priority_levels_on
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ========================================
	// Read answers one cycle after the address is taken
	sequence s_ar(logic [7:0] a);
		i_ce && i_arvalid && o_arready && i_araddr == a;
	endsequence
	property p_en_a_gap;
		s_ar(PIE_OFS_EN_A) |=> o_rvalid && !o_rdata[2];
	endproperty
	a_en_a_gap: assert property (p_en_a_gap) else $error("enable A bit 2 read one");
	property p_en_b_gap;
		s_ar(PIE_OFS_EN_B) |=> o_rvalid && o_rdata[7:5] == 3'h0 && !o_rdata[0];
	endproperty
	a_en_b_gap: assert property (p_en_b_gap) else $error("enable B spare bits read one");
	property p_pr_a_one;
		s_ar(PIE_OFS_PR_A) |=> o_rvalid && o_rdata[2];
	endproperty
	a_pr_a_one: assert property (p_pr_a_one) else $error("priority A bit 2 read zero");
	property p_pr_b_gap;
		s_ar(PIE_OFS_PR_B) |=> o_rvalid && o_rdata[7:5] == 3'h0;
	endproperty
	a_pr_b_gap: assert property (p_pr_b_gap) else $error("priority B top bits read one");
	property p_rd_hold;
		o_rvalid && !(i_rready && i_ce) |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved before taken");
	property p_rd_byte;
		o_rvalid |-> o_rdata[31:8] == 24'h0;
	endproperty
	a_rd_byte: assert property (p_rd_byte) else $error("read data above byte not zero");
	property p_b_hold;
		o_bvalid && !(i_bready && i_ce) |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response moved before taken");
	// The request register lags the control bit by one edge, so the bit before that edge decides
	property p_no_low;
		$past(i_ce) && o_irq_low |-> $past(o_priority_levels_on);
	endproperty
	a_no_low: assert property (p_no_low) else $error("low request with levels off");
	property p_irq_or;
		o_irq == (o_irq_high || o_irq_low);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("request output not the union");
	// Clock enable low holds every registered output
	property p_ce_freeze;
		!i_ce |=> $stable(o_irq_high) && $stable(o_irq_low) && $stable(o_rvalid) && $stable(o_bvalid)
			&& $stable(o_priority_levels_on);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");
endmodule

bind pie_top pie_chk #(.ADDR_W(ADDR_W)) pie_chk_inst (.*);

//--- verif/pie_src_model.sv
// Peripheral event sources: one-cycle pulses launched on command
`timescale 1ns/1ns

module pie_src_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_fire_a,
	input wire logic [7:0] i_fire_b,
	output logic [7:0] o_event_a,
	output logic [7:0] o_event_b
);
	// Registered so pulses never change in the edge's own time step
	always_ff @(posedge i_clk_sys) begin
		o_event_a <= i_fire_a;
		o_event_b <= i_fire_b;
	end
endmodule

//--- verif/test_peripheral_irq_enable_priority.sv
// Self-checking bench for the peripheral interrupt enable/priority bank
`timescale 1ns/1ns

module test_peripheral_irq_enable_priority;
	import pie_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] fire_a = 8'h00, fire_b = 8'h00, ev_a, ev_b, i_awaddr = 8'h00, i_araddr = 8'h00;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_ce = 1'b1;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic [3:0] i_wstrb = 4'hf;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_high, o_irq_low, o_irq, o_lv;
	logic [1:0] o_bresp, o_rresp, r;
	logic [7:0] a, v;
	int bad_count = 0, total_checks = 0, seed = 73, i;
	logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'hff, 8'h1f, 8'h00, 8'h00, 8'h00};

	pie_src_model pie_src_model_inst (.i_clk_sys(i_clk_sys), .i_fire_a(fire_a), .i_fire_b(fire_b),
		.o_event_a(ev_a), .o_event_b(ev_b));
	pie_top pie_top_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_event_a(ev_a), .i_event_b(ev_b),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
		.i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
		.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.o_irq_high(o_irq_high), .o_irq_low(o_irq_low), .o_irq(o_irq), .o_priority_levels_on(o_lv));

	initial forever #5 i_clk_sys = ~i_clk_sys;

	// ========================================
	// Checking and bus tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Handshakes sampled at the falling edge equal what the next rising edge sees
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		logic aw, w, b;
		b = 1'b0;
		@(posedge i_clk_sys);
		i_awaddr <= ad;
		i_wdata <= dt;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		// Only the watchdog ends a wait for a response that never comes
		while (!b) begin
			@(negedge i_clk_sys);
			aw = i_awvalid & o_awready;
			w = i_wvalid & o_wready;
			b = o_bvalid;
			r = o_bresp;
			@(posedge i_clk_sys);
			if (aw) i_awvalid <= 1'b0;
			if (w) i_wvalid <= 1'b0;
			if (b) i_bready <= 1'b0;
		end
		chk("aw and w taken", 1, !i_awvalid && !i_wvalid);
	endtask
	task rd(input logic [7:0] ad);
		logic t, ar;
		t = 1'b0;
		@(posedge i_clk_sys);
		i_araddr <= ad;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		while (!t) begin
			@(negedge i_clk_sys);
			ar = i_arvalid & o_arready;
			t = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk_sys);
			if (ar) i_arvalid <= 1'b0;
			if (t) i_rready <= 1'b0;
		end
		chk("ar taken", 1, !i_arvalid);
	endtask
	function automatic logic [31:0] exp_rd(logic [7:0] ad, logic [7:0] x);
		case (ad)
			8'h00: return {24'h0, x & 8'hfb};
			8'h04: return {24'h0, x & 8'h1e};
			8'h08: return {24'h0, (x & 8'hfb) | 8'h04};
			8'h0c: return {24'h0, (x & 8'h1e) | 8'h01};
			default: return 32'h0;
		endcase
	endfunction
	task wrchk(input logic [7:0] ad, input logic [7:0] x);
		wr(ad, {24'h0, x});
		chk("bresp", 0, r);
		rd(ad);
		chk("readback", exp_rd(ad, x), d);
	endtask
	task irq_is(input logic h, input logic l);
		repeat (4) @(negedge i_clk_sys);
		chk("irq high", h, o_irq_high);
		chk("irq low", l, o_irq_low);
		chk("irq any", h | l, o_irq);
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		for (i = 0; i < 7; i++) begin
			rd(8'(i * 4));
			chk("reset value", {24'h0, rst_tab[i]}, d);
		end
		rd(8'h1c);
		chk("unmapped rresp", 3, r);
		wr(8'h20, 32'hff);
		chk("unmapped bresp", 3, r);
		for (i = 0; i < 4; i++) begin
			wrchk(8'(i * 4), 8'hff);
			wrchk(8'(i * 4), 8'h00);
		end
		for (i = 0; i < 24; i++) begin
			a = 8'(($random(seed) & 3) * 4);
			v = 8'($random(seed));
			wrchk(a, v);
		end
		// Lane 0 strobe low: the write is answered but must not land
		wr(PIE_OFS_EN_A, 32'h00);
		i_wstrb <= 4'he;
		wr(PIE_OFS_EN_A, 32'hff);
		chk("lane 0 off bresp", 0, r);
		i_wstrb <= 4'hf;
		rd(PIE_OFS_EN_A);
		chk("lane 0 off", 32'h0, d);
		// Kernel setup: timer-2 match is the only high source
		wr(PIE_OFS_CTRL, 32'h07);
		chk("levels on", 1, o_lv);
		wr(PIE_OFS_EN_A, 32'h02);
		wr(PIE_OFS_PR_A, 32'h02);
		wr(PIE_OFS_PR_B, 32'h00);
		wr(PIE_OFS_EN_B, 32'h00);
		@(posedge i_clk_sys);
		fire_a <= 8'h02;
		fire_b <= 8'h08;
		@(posedge i_clk_sys);
		fire_a <= 8'h00;
		fire_b <= 8'h00;
		irq_is(1'b1, 1'b0);
		rd(PIE_OFS_FLAG_B);
		chk("masked flag", 32'h08, d);
		wr(PIE_OFS_EN_B, 32'h08);
		irq_is(1'b1, 1'b1);
		wr(PIE_OFS_CTRL, 32'h03);
		irq_is(1'b1, 1'b0);
		wr(PIE_OFS_CTRL, 32'h02);
		irq_is(1'b0, 1'b0);
		chk("levels on", 0, o_lv);
		wr(PIE_OFS_CTRL, 32'h06);
		irq_is(1'b1, 1'b0);
		// Only the low-priority source is left; with levels off it still raises the request
		wr(PIE_OFS_FLAG_A, 32'h02);
		irq_is(1'b1, 1'b0);
		wr(PIE_OFS_FLAG_B, 32'h08);
		irq_is(1'b0, 1'b0);
		// Clock enable low: an event inside the frozen window is not seen
		@(posedge i_clk_sys);
		i_ce <= 1'b0;
		fire_a <= 8'h02;
		@(posedge i_clk_sys);
		fire_a <= 8'h00;
		repeat (2) @(posedge i_clk_sys);
		i_ce <= 1'b1;
		irq_is(1'b0, 1'b0);
		rd(PIE_OFS_FLAG_A);
		chk("frozen flag", 32'h0, d);
		// Second reset in mid-run brings every register back
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		for (i = 0; i < 7; i++) begin
			rd(8'(i * 4));
			chk("reset again", {24'h0, rst_tab[i]}, d);
		end
		results;
	end

	initial begin
		#300000;
		bad_count++;
		results;
	end
endmodule
